// [core/sfpcs_defs.vh]
`ifndef SFPCS_DEFS_VH
`define SFPCS_DEFS_VH

// control/status field positions
`define SFPCS_FLAG_LSB 0
`define SFPCS_FLAG_MSB 5
`define SFPCS_ZERO_IN_BIT 6
`define SFPCS_MASK_LSB 7
`define SFPCS_MASK_MSB 12
`define SFPCS_RND_LSB 13
`define SFPCS_RND_MSB 14
`define SFPCS_FLUSH_BIT 15
`define SFPCS_RSVD_LSB 16
`define SFPCS_RSVD_MSB 31

// exception order within flags and masks
`define SFPCS_EXC_INVALID 0
`define SFPCS_EXC_SUBNORM 1
`define SFPCS_EXC_DIVZERO 2
`define SFPCS_EXC_OVERFLOW 3
`define SFPCS_EXC_UNDERFLOW 4
`define SFPCS_EXC_PRECISION 5

// reset value: all masks set, modes off, flags clear
`define SFPCS_RESET_VAL 32'h00001F80

// writable bits with and without the zeroed-input feature
`define SFPCS_WMASK_FULL 32'h0000FFFF
`define SFPCS_WMASK_NOZI 32'h0000FFBF

// rounding modes
`define SFPCS_RND_NEAREST 2'h0
`define SFPCS_RND_DOWN 2'h1
`define SFPCS_RND_UP 2'h2
`define SFPCS_RND_TRUNC 2'h3

// write sources
`define SFPCS_SRC_NONE 2'h0
`define SFPCS_SRC_LOAD 2'h1
`define SFPCS_SRC_RESTORE 2'h2

// alignment sizes in bytes
`define SFPCS_PACKED_ALIGN 16
`define SFPCS_SCALAR_BYTES 4

`endif

// [core/sfpcs_operand_check.v]
`timescale 1ns/1ps
`default_nettype none
`include "sfpcs_defs.vh"

module sfpcs_operand_check #(
    parameter AW = 32
) (
    input wire [AW-1:0] addr,
    input wire packed_op,
    input wire unaligned_ok,
    input wire zeroed_inputs_on,
    input wire [31:0] src_a,
    input wire [31:0] src_b,
    output reg align_fault,
    output reg [31:0] opnd_a,
    output reg [31:0] opnd_b,
    output reg subnorm_seen
);
    function is_subnormal;
        input [31:0] v;
        begin
            is_subnormal = (v[30:23] == 8'h00) && (v[22:0] != 23'h000000);
        end
    endfunction

    function [31:0] zero_if_subnormal;
        input [31:0] v;
        input en;
        begin
            zero_if_subnormal = (en && is_subnormal(v)) ? {v[31], 31'h00000000} : v;
        end
    endfunction

    always @* begin
        align_fault = packed_op && !unaligned_ok && (addr[3:0] != 4'h0);
        opnd_a = zero_if_subnormal(src_a, zeroed_inputs_on);
        opnd_b = zero_if_subnormal(src_b, zeroed_inputs_on);
        // no subnormal event when inputs are zeroed
        subnorm_seen = !zeroed_inputs_on && (is_subnormal(src_a) || is_subnormal(src_b));
    end
endmodule
`default_nettype wire

// [core/sfpcs_top.v]
// How it works
// - one 32-bit register: flags, masks, rounding, flush and zeroed-input enables
// - written by load and restore, read by store and save instructions
// - bits 16 to 31 reserved, zero after reset
// - nonzero reserved bits on write give protection fault, no update
// - bits 0 to 5 are sticky exception flags
// - flags clear only when software writes zero via load or restore
// - bits 7 to 12 mask exceptions; set means masked
// - all six masks set after reset
// - unmasking a set flag raises nothing; next detecting instruction does
// - bits 13 and 14 select result rounding
// - flush on with underflow masked: signed zero, set precision and underflow
// - underflow unmasked: flush enable ignored
// - flush enable clear after reset
// - bit 6 set: subnormal inputs become signed zeros before compute
// - zeroed inputs: no subnormal-input flag nor exception
// - zeroed-input enable clear after reset
// - zeroed-input enable applies to single and double precision; here OP_DOUBLE is unused and operands are decoded as 32-bit single only
// - without feature bit 6 reserved, setting faults; save reports writable bits
// - packed operands 16-byte aligned except unaligned move and 4-byte scalar
`timescale 1ns/1ps
`default_nettype none
`include "sfpcs_defs.vh"

module sfpcs_top #(
    parameter HAS_ZERO_IN = 1,
    parameter AW = 32
) (
    input wire CLK_SYS,
    input wire ARST_N,
    input wire LOAD_FP_CONTROL_INSN,
    input wire FULL_STATE_RESTORE_INSN,
    input wire [31:0] WR_DATA,
    input wire STORE_FP_CONTROL_INSN,
    input wire FULL_STATE_SAVE_INSN,
    input wire OP_VALID,
    input wire OP_DOUBLE,
    input wire [5:0] OP_EXC_RAW,
    input wire OP_RESULT_SIGN,
    input wire [AW-1:0] OP_ADDR,
    input wire OP_PACKED_MEM,
    input wire OP_UNALIGNED_MOVE,
    input wire [31:0] OP_SRC_A,
    input wire [31:0] OP_SRC_B,
    output reg [31:0] RD_DATA,
    output reg [31:0] WRITABLE_BITS_MASK,
    output reg RD_VALID,
    output reg PROTECTION_FAULT,
    output reg SIMD_EXCEPTION,
    output reg [5:0] SIMD_EXC_CAUSE,
    output reg FLUSH_RESULT,
    output reg FLUSH_SIGN,
    output reg [31:0] OPND_A,
    output reg [31:0] OPND_B,
    output reg [1:0] ROUND_MODE_FIELD,
    output reg FLUSH_UNDERFLOW_TO_ZERO,
    output reg SUBNORMAL_INPUTS_ZEROED
);
    localparam [31:0] WMASK = (HAS_ZERO_IN != 0) ? `SFPCS_WMASK_FULL : `SFPCS_WMASK_NOZI;

    reg [31:0] csr_q;
    reg [31:0] csr_d;
    reg [1:0] wsrc;
    reg wr_fault;
    reg [5:0] flags_set;
    reg [5:0] unmasked_hit;
    reg flush_now;

    wire [5:0] flags_q = csr_q[`SFPCS_FLAG_MSB:`SFPCS_FLAG_LSB];
    wire [5:0] masks_q = csr_q[`SFPCS_MASK_MSB:`SFPCS_MASK_LSB];
    wire zero_in_q = csr_q[`SFPCS_ZERO_IN_BIT];
    wire flush_q = csr_q[`SFPCS_FLUSH_BIT];
    wire align_fault;
    wire [31:0] opnd_a;
    wire [31:0] opnd_b;
    wire subnorm_seen;

    // zeroed-input handling is precision independent
    sfpcs_operand_check #(
        .AW(AW)
    ) u_check (
        .addr(OP_ADDR),
        .packed_op(OP_PACKED_MEM),
        .unaligned_ok(OP_UNALIGNED_MOVE),
        .zeroed_inputs_on(zero_in_q),
        .src_a(OP_SRC_A),
        .src_b(OP_SRC_B),
        .align_fault(align_fault),
        .opnd_a(opnd_a),
        .opnd_b(opnd_b),
        .subnorm_seen(subnorm_seen)
    );

    always @* begin
        wsrc = LOAD_FP_CONTROL_INSN ? `SFPCS_SRC_LOAD :
               FULL_STATE_RESTORE_INSN ? `SFPCS_SRC_RESTORE : `SFPCS_SRC_NONE;
        wr_fault = (wsrc != `SFPCS_SRC_NONE) && ((WR_DATA & ~WMASK) != 32'h00000000);
        flags_set = 6'h00;
        flush_now = 1'b0;
        if (OP_VALID && !align_fault) begin
            flags_set = OP_EXC_RAW;
            // datapath subnormal report always replaced by the operand check's subnorm_seen
            flags_set[`SFPCS_EXC_SUBNORM] = subnorm_seen;
            // masked underflow with flush enabled; unmasked ignores flush
            if (OP_EXC_RAW[`SFPCS_EXC_UNDERFLOW] && masks_q[`SFPCS_EXC_UNDERFLOW] &&
                    flush_q) begin
                flush_now = 1'b1;
                flags_set[`SFPCS_EXC_PRECISION] = 1'b1;
            end
        end
        // only an instruction's own detection raises an exception
        unmasked_hit = flags_set & ~masks_q;
        csr_d = csr_q;
        if (wsrc != `SFPCS_SRC_NONE && !wr_fault) begin
            csr_d = WR_DATA & WMASK;
        end
        // hardware set wins over a same-cycle write of zero
        csr_d[`SFPCS_FLAG_MSB:`SFPCS_FLAG_LSB] =
            csr_d[`SFPCS_FLAG_MSB:`SFPCS_FLAG_LSB] | flags_set;
        csr_d[`SFPCS_RSVD_MSB:`SFPCS_RSVD_LSB] = 16'h0000;
    end

    always @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            csr_q <= `SFPCS_RESET_VAL;
            RD_DATA <= 32'h00000000;
            WRITABLE_BITS_MASK <= 32'h00000000;
            RD_VALID <= 1'b0;
            PROTECTION_FAULT <= 1'b0;
            SIMD_EXCEPTION <= 1'b0;
            SIMD_EXC_CAUSE <= 6'h00;
            FLUSH_RESULT <= 1'b0;
            FLUSH_SIGN <= 1'b0;
            OPND_A <= 32'h00000000;
            OPND_B <= 32'h00000000;
            ROUND_MODE_FIELD <= `SFPCS_RND_NEAREST;
            FLUSH_UNDERFLOW_TO_ZERO <= 1'b0;
            SUBNORMAL_INPUTS_ZEROED <= 1'b0;
        end else begin
            csr_q <= csr_d;
            RD_VALID <= STORE_FP_CONTROL_INSN || FULL_STATE_SAVE_INSN;
            if (STORE_FP_CONTROL_INSN || FULL_STATE_SAVE_INSN) begin
                RD_DATA <= csr_q;
            end
            if (FULL_STATE_SAVE_INSN) begin
                WRITABLE_BITS_MASK <= WMASK;
            end
            PROTECTION_FAULT <= wr_fault || (OP_VALID && align_fault);
            SIMD_EXCEPTION <= unmasked_hit != 6'h00;
            SIMD_EXC_CAUSE <= unmasked_hit;
            FLUSH_RESULT <= flush_now;
            FLUSH_SIGN <= flush_now && OP_RESULT_SIGN;
            OPND_A <= opnd_a;
            OPND_B <= opnd_b;
            ROUND_MODE_FIELD <= csr_d[`SFPCS_RND_MSB:`SFPCS_RND_LSB];
            FLUSH_UNDERFLOW_TO_ZERO <= csr_d[`SFPCS_FLUSH_BIT];
            SUBNORMAL_INPUTS_ZEROED <= csr_d[`SFPCS_ZERO_IN_BIT];
        end
    end
endmodule
`default_nettype wire

// [test/sfpcs_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module sfpcs_monitor #(
    parameter int AW = 32
) (
    input wire logic CLK_SYS,
    input wire logic ARST_N,
    input wire logic LOAD_FP_CONTROL_INSN,
    input wire logic FULL_STATE_RESTORE_INSN,
    input wire logic [31:0] WR_DATA,
    input wire logic STORE_FP_CONTROL_INSN,
    input wire logic FULL_STATE_SAVE_INSN,
    input wire logic OP_VALID,
    input wire logic [AW-1:0] OP_ADDR,
    input wire logic OP_PACKED_MEM,
    input wire logic OP_UNALIGNED_MOVE,
    input wire logic RD_VALID,
    input wire logic PROTECTION_FAULT,
    input wire logic SIMD_EXCEPTION,
    input wire logic FLUSH_RESULT,
    input wire logic [1:0] ROUND_MODE_FIELD,
    input wire logic FLUSH_UNDERFLOW_TO_ZERO
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!ARST_N);
    wire wr = LOAD_FP_CONTROL_INSN | FULL_STATE_RESTORE_INSN;
    wire bad = wr && (|WR_DATA[31:16]);
    wire rd = STORE_FP_CONTROL_INSN | FULL_STATE_SAVE_INSN;
    sequence s_rv; ##1 RD_VALID; endsequence
    property p_rd; rd |-> s_rv; endproperty
    a_rd: assert property (p_rd) else $error("read not answered");
    property p_nord; !rd |=> !RD_VALID; endproperty
    a_nord: assert property (p_nord) else $error("stray read valid");
    property p_rsv; bad |=> PROTECTION_FAULT; endproperty
    a_rsv: assert property (p_rsv) else $error("no fault");
    property p_hold; bad |=> $stable({FLUSH_UNDERFLOW_TO_ZERO, ROUND_MODE_FIELD}); endproperty
    a_hold: assert property (p_hold) else $error("refused write landed");
    property p_mir;
        wr && !bad |=> {FLUSH_UNDERFLOW_TO_ZERO, ROUND_MODE_FIELD} == $past(WR_DATA[15:13]);
    endproperty
    a_mir: assert property (p_mir) else $error("mode not written");
    property p_nox; wr && !OP_VALID |=> !SIMD_EXCEPTION; endproperty
    a_nox: assert property (p_nox) else $error("write raised exception");
    property p_nofz; !(OP_VALID && FLUSH_UNDERFLOW_TO_ZERO) |=> !FLUSH_RESULT; endproperty
    a_nofz: assert property (p_nofz) else $error("flush without enable");
    property p_align;
        OP_VALID && OP_PACKED_MEM && !OP_UNALIGNED_MOVE && |OP_ADDR[3:0] |=> PROTECTION_FAULT;
    endproperty
    a_align: assert property (p_align) else $error("misaligned op passed");
endmodule
`default_nettype wire

// [test/sfpcs_dp_model.sv]
`timescale 1ns/1ps
`default_nettype none
module sfpcs_dp_model (
    input wire logic CLK_SYS,
    output logic OP_VALID,
    output logic [5:0] OP_EXC_RAW,
    output logic OP_RESULT_SIGN,
    output logic [31:0] OP_ADDR,
    output logic OP_PACKED_MEM,
    output logic [31:0] OP_SRC_A
);
    initial {OP_VALID, OP_EXC_RAW, OP_RESULT_SIGN, OP_ADDR, OP_PACKED_MEM, OP_SRC_A} = '0;
    // nonzero address means a packed memory operand
    task issue(input logic [5:0] e, input logic s, input logic [31:0] a, d);
        @(posedge CLK_SYS);
        {OP_VALID, OP_EXC_RAW, OP_RESULT_SIGN, OP_SRC_A} <= {1'b1, e, s, a};
        {OP_ADDR, OP_PACKED_MEM} <= {d, |d};
        @(posedge CLK_SYS);
        {OP_VALID, OP_EXC_RAW, OP_SRC_A} <= {1'b0, ~e, ~a};
        @(negedge CLK_SYS);
    endtask
endmodule
`default_nettype wire

// [test/test_simd_fp_control_status.sv]
`timescale 1ns/1ps
`default_nettype none
module test_simd_fp_control_status;
    logic CLK_SYS = 0, ARST_N = 0, LOAD_FP_CONTROL_INSN = 0, FULL_STATE_RESTORE_INSN = 0;
    logic STORE_FP_CONTROL_INSN = 0, FULL_STATE_SAVE_INSN = 0, OP_DOUBLE = 1;
    logic OP_UNALIGNED_MOVE = 0, RD_VALID, PROTECTION_FAULT, SIMD_EXCEPTION, FLUSH_RESULT;
    logic FLUSH_SIGN, FLUSH_UNDERFLOW_TO_ZERO, SUBNORMAL_INPUTS_ZEROED, OP_VALID;
    logic OP_RESULT_SIGN, OP_PACKED_MEM;
    logic [31:0] WR_DATA = 0, OP_SRC_B = 0, RD_DATA, WRITABLE_BITS_MASK, OP_ADDR, OP_SRC_A;
    logic [31:0] OPND_A, OPND_B, lf = 32'hB30C9C03, v, q[$];
    logic [5:0] OP_EXC_RAW, SIMD_EXC_CAUSE;
    logic [1:0] ROUND_MODE_FIELD;
    int fails = 0, comparisons = 0, cyc = 0;
    always #2.5 CLK_SYS = ~CLK_SYS;
    sfpcs_dp_model dp (.*);
    sfpcs_top DUT (.*);
    function logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task chk(input string n, input logic [31:0] e, g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task end_sim;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task wr(input logic r, input logic [31:0] d);
        @(posedge CLK_SYS);
        LOAD_FP_CONTROL_INSN <= !r;
        FULL_STATE_RESTORE_INSN <= r;
        WR_DATA <= d;
        @(posedge CLK_SYS);
        LOAD_FP_CONTROL_INSN <= 0;
        FULL_STATE_RESTORE_INSN <= 0;
        @(negedge CLK_SYS);
    endtask
    task rdt(input logic s, input logic [31:0] e);
        @(posedge CLK_SYS);
        STORE_FP_CONTROL_INSN <= !s;
        FULL_STATE_SAVE_INSN <= s;
        q.push_back(e);
        @(posedge CLK_SYS);
        STORE_FP_CONTROL_INSN <= 0;
        FULL_STATE_SAVE_INSN <= 0;
        @(negedge CLK_SYS);
    endtask
    // queued expectations meet results as they appear
    always @(posedge CLK_SYS) if (RD_VALID === 1'b1) chk("rd_data", q.pop_front(), RD_DATA);
    always @(posedge CLK_SYS) begin
        cyc++;
        if (cyc == 1000) begin
            fails++;
            end_sim;
        end
    end
    initial begin
        repeat (2) @(posedge CLK_SYS);
        ARST_N <= 1;
        rdt(0, 32'h00001F80);
        wr(0, 32'h00011F80);
        chk("fault", 1, PROTECTION_FAULT);
        rdt(1, 32'h00001F80);
        chk("wmask", 32'h0000FFFF, WRITABLE_BITS_MASK);
        for (int i = 0; i < 4; i++) begin
            lf = nx(lf);
            v = {16'h0, lf[15], i[1:0], 13'h003F};
            wr(i[0], v);
            chk("round", i[1:0], ROUND_MODE_FIELD);
            chk("exc", 0, SIMD_EXCEPTION);
            rdt(0, v);
        end
        wr(0, 32'h0000803F);
        dp.issue(6'h10, 1, 32'h3F800000, 0);
        chk("flush", 0, FLUSH_RESULT);
        chk("cause", 6'h10, SIMD_EXC_CAUSE);
        chk("exc", 1, SIMD_EXCEPTION);
        wr(0, 32'h00009F80);
        dp.issue(6'h10, lf[0], 32'h3F800000, 0);
        chk("flush", 1, FLUSH_RESULT);
        chk("sign", lf[0], FLUSH_SIGN);
        dp.issue(6'h01, 0, 32'h3F800000, 32'h4);
        chk("fault", 1, PROTECTION_FAULT);
        dp.issue(6'h00, 0, 32'h3F800000, 32'h10);
        chk("fault", 0, PROTECTION_FAULT);
        rdt(0, 32'h00009FB0);
        wr(0, 32'h00001FC0);
        chk("zin", 1, SUBNORMAL_INPUTS_ZEROED);
        OP_SRC_B <= 32'h00000005;
        dp.issue(6'h00, 0, 32'h80000001, 0);
        chk("opnd", 32'h80000000, OPND_A);
        chk("opnd_b", 32'h00000000, OPND_B);
        rdt(0, 32'h00001FC0);
        wr(1, 32'h00001F80);
        dp.issue(6'h00, 0, 32'h80000001, 0);
        chk("opnd", 32'h80000001, OPND_A);
        chk("opnd_b", 32'h00000005, OPND_B);
        rdt(0, 32'h00001F82);
        repeat (3) @(posedge CLK_SYS);
        end_sim;
    end
endmodule
bind sfpcs_top sfpcs_monitor #(.AW(AW)) u_mon (.*);
`default_nettype wire
